// ==== logic/ret_rot_pkg.sv ====
// Constants for the return and rotate execution slice.
// Assumes the core decoder presents one decoded operation per instruction cycle.
package ret_rot_pkg;
  localparam logic [7:0] W_RESET     = 8'h00;
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam logic [3:0] BANK_RESET  = 4'h0;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [3:0] ACCESS_BANK = 4'h0;
  // Flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 4;
  // Cycles taken by the return operations
  localparam int RET_CYCLES = 2;
  typedef enum logic [2:0] {
    OP_NONE, OP_RETFI, OP_RETSUB, OP_RETLIT, OP_RLC, OP_RLNC, OP_RRC, OP_SWRESET
  } op_t;
endpackage

// ==== logic/return_and_rotate_exec.sv ====
// Execution slice for return, return-with-literal, rotate and software reset.
// Assumes the decoder holds op_in steady for one cycle when op_valid_in is high,
// and that the return stack and file memory sit outside this block.
`timescale 1ns/10ps
`default_nettype none
module return_and_rotate_exec
(
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // Decoded operation
  input  wire logic              op_valid_in,
  input  wire ret_rot_pkg::op_t  op_in,
  input  wire logic              shadow_sel_in,
  input  wire logic              dest_in,
  input  wire logic              access_in,
  input  wire logic [7:0]        literal_in,
  input  wire logic              high_priority_in,
  // File register and stack
  input  wire logic [7:0]        file_data_in,
  input  wire logic [20:0]       stack_top_in,
  // Shadows
  input  wire logic [7:0]        working_shadow_in,
  input  wire logic [4:0]        flags_shadow_in,
  input  wire logic [3:0]        bank_select_shadow_in,
  // Latch writes from other instructions
  input  wire logic              latch_we_in,
  input  wire logic [7:0]        latch_upper_in,
  input  wire logic [7:0]        latch_high_in,
  // Architectural state
  output logic [7:0]             working_out,
  output logic [4:0]             flags_out,
  output logic [3:0]             bank_select_reg_out,
  output logic [7:0]             pc_latch_upper_out,
  output logic [7:0]             pc_latch_high_out,
  output logic                   global_int_enable_high_out,
  output logic                   peripheral_int_enable_low_out,
  // Stack and pc
  output logic                   stack_pop_out,
  output logic                   pc_load_out,
  output logic [20:0]            pc_value_out,
  // File write, bank, busy and master clear
  output logic                   file_we_out,
  output logic [7:0]             file_wdata_out,
  output logic [3:0]             file_bank_out,
  output logic                   busy_out,
  output logic                   master_clear_out
);
  logic [7:0] rot_res;
  logic       rot_c;
  logic       is_rot;
  logic       is_ret;
  logic       start;
  logic [1:0] cyc_ff;

  // Second cycle of a return is idle; new ops are ignored then
  assign start  = op_valid_in && (cyc_ff == 2'h0);
  assign is_rot = (op_in == ret_rot_pkg::OP_RLC) || (op_in == ret_rot_pkg::OP_RLNC) ||
                  (op_in == ret_rot_pkg::OP_RRC);
  assign is_ret = (op_in == ret_rot_pkg::OP_RETFI) || (op_in == ret_rot_pkg::OP_RETSUB) ||
                  (op_in == ret_rot_pkg::OP_RETLIT);

  always_comb
  begin
    rot_res = file_data_in;
    rot_c   = flags_out[ret_rot_pkg::FLAG_C];
    unique case (op_in)
      ret_rot_pkg::OP_RLC:
      begin
        rot_res = {file_data_in[6:0], flags_out[ret_rot_pkg::FLAG_C]};
        rot_c   = file_data_in[7];
      end
      ret_rot_pkg::OP_RLNC:
      begin
        rot_res = {file_data_in[6:0], file_data_in[7]};
      end
      ret_rot_pkg::OP_RRC:
      begin
        rot_res = {flags_out[ret_rot_pkg::FLAG_C], file_data_in[7:1]};
        rot_c   = file_data_in[0];
      end
      default:
      begin
        rot_res = file_data_in;
      end
    endcase
  end

  // Cycle counter for the two-cycle returns
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      cyc_ff <= 2'h0;
    else if (start && is_ret)
      cyc_ff <= 2'(ret_rot_pkg::RET_CYCLES - 1);
    else if (cyc_ff != 2'h0)
      cyc_ff <= cyc_ff - 2'h1;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      busy_out <= 1'b0;
    else
      busy_out <= start && is_ret;
  end

  // Working register
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      working_out <= ret_rot_pkg::W_RESET;
    else if (start && op_in == ret_rot_pkg::OP_SWRESET)
      working_out <= ret_rot_pkg::W_RESET;
    else if (start && op_in == ret_rot_pkg::OP_RETLIT)
      working_out <= literal_in;
    else if (start && (op_in == ret_rot_pkg::OP_RETFI || op_in == ret_rot_pkg::OP_RETSUB)
             && shadow_sel_in)
      working_out <= working_shadow_in;
    else if (start && is_rot && !dest_in)
      working_out <= rot_res;
  end

  // Flags
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      flags_out <= ret_rot_pkg::FLAGS_RESET;
    else if (start && op_in == ret_rot_pkg::OP_SWRESET)
      flags_out <= ret_rot_pkg::FLAGS_RESET;
    else if (start && (op_in == ret_rot_pkg::OP_RETFI || op_in == ret_rot_pkg::OP_RETSUB)
             && shadow_sel_in)
      flags_out <= flags_shadow_in;
    else if (start && is_rot)
    begin
      flags_out[ret_rot_pkg::FLAG_N] <= rot_res[7];
      flags_out[ret_rot_pkg::FLAG_Z] <= (rot_res == 8'h00);
      if (op_in != ret_rot_pkg::OP_RLNC)
        flags_out[ret_rot_pkg::FLAG_C] <= rot_c;
    end
  end

  // Bank select
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      bank_select_reg_out <= ret_rot_pkg::BANK_RESET;
    else if (start && op_in == ret_rot_pkg::OP_SWRESET)
      bank_select_reg_out <= ret_rot_pkg::BANK_RESET;
    else if (start && (op_in == ret_rot_pkg::OP_RETFI || op_in == ret_rot_pkg::OP_RETSUB)
             && shadow_sel_in)
      bank_select_reg_out <= bank_select_shadow_in;
  end

  // Pc latches: returns never touch them
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pc_latch_upper_out <= ret_rot_pkg::LATCH_RESET;
      pc_latch_high_out  <= ret_rot_pkg::LATCH_RESET;
    end
    else if (start && op_in == ret_rot_pkg::OP_SWRESET)
    begin
      pc_latch_upper_out <= ret_rot_pkg::LATCH_RESET;
      pc_latch_high_out  <= ret_rot_pkg::LATCH_RESET;
    end
    else if (latch_we_in && !(start && is_ret))
    begin
      pc_latch_upper_out <= latch_upper_in;
      pc_latch_high_out  <= latch_high_in;
    end
  end

  // Interrupt enables
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      global_int_enable_high_out    <= 1'b0;
      peripheral_int_enable_low_out <= 1'b0;
    end
    else if (start && op_in == ret_rot_pkg::OP_SWRESET)
    begin
      global_int_enable_high_out    <= 1'b0;
      peripheral_int_enable_low_out <= 1'b0;
    end
    else if (start && op_in == ret_rot_pkg::OP_RETFI)
    begin
      if (high_priority_in)
        global_int_enable_high_out <= 1'b1;
      else
        peripheral_int_enable_low_out <= 1'b1;
    end
  end

  // Stack pop and pc load
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      stack_pop_out <= 1'b0;
      pc_load_out   <= 1'b0;
      pc_value_out  <= 21'h000000;
    end
    else
    begin
      stack_pop_out <= start && is_ret;
      pc_load_out   <= start && (is_ret || op_in == ret_rot_pkg::OP_SWRESET);
      if (start && is_ret)
        pc_value_out <= stack_top_in;
      else if (start && op_in == ret_rot_pkg::OP_SWRESET)
        pc_value_out <= 21'h000000;
    end
  end

  // File write-back, bank choice and reset request
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      file_we_out      <= 1'b0;
      file_wdata_out   <= 8'h00;
      file_bank_out    <= ret_rot_pkg::ACCESS_BANK;
      master_clear_out <= 1'b0;
    end
    else
    begin
      file_we_out      <= start && is_rot && dest_in;
      file_wdata_out   <= rot_res;
      file_bank_out    <= access_in ? bank_select_reg_out : ret_rot_pkg::ACCESS_BANK;
      master_clear_out <= start && (op_in == ret_rot_pkg::OP_SWRESET);
    end
  end
endmodule
`default_nettype wire

// ==== tb/ret_rot_properties.sv ====
// Timing checks for the return and rotate slice.
// Bound to the top module and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module ret_rot_properties
(
  // Watched ports
  input wire logic             clk_in,
  input wire logic             rst_in,
  input wire logic             op_valid_in,
  input wire ret_rot_pkg::op_t op_in,
  input wire logic             dest_in,
  input wire logic             access_in,
  input wire logic [7:0]       literal_in,
  input wire logic [7:0]       file_data_in,
  input wire logic [20:0]      stack_top_in,
  input wire logic [7:0]       working_out,
  input wire logic [4:0]       flags_out,
  input wire logic             stack_pop_out,
  input wire logic             pc_load_out,
  input wire logic [20:0]      pc_value_out,
  input wire logic             file_we_out,
  input wire logic [3:0]       file_bank_out,
  input wire logic             busy_out
);
  wire logic take = op_valid_in && !busy_out;
  wire logic ret = op_in >= ret_rot_pkg::OP_RETFI && op_in <= ret_rot_pkg::OP_RETLIT;
  wire logic rot = op_in >= ret_rot_pkg::OP_RLC && op_in <= ret_rot_pkg::OP_RRC;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  chk_ret_pops: assert property (take && ret |=> stack_pop_out && pc_load_out)
    else $error("return did not pop");
  chk_second_idle: assert property (take && ret |=> busy_out ##1 !pc_load_out)
    else $error("second return cycle not idle");
  chk_pc_top: assert property (take && ret |=> pc_value_out == $past(stack_top_in))
    else $error("pc not from stack top");
  chk_lit_w: assert property (take && op_in == ret_rot_pkg::OP_RETLIT |=>
    working_out == $past(literal_in))
    else $error("literal not in working");
  chk_rlc_carry: assert property (take && op_in == ret_rot_pkg::OP_RLC |=>
    flags_out[0] == $past(file_data_in[7]))
    else $error("left carry wrong");
  chk_rlnc_keep: assert property (take && op_in == ret_rot_pkg::OP_RLNC |=>
    $stable(flags_out[0]))
    else $error("carry changed");
  chk_rrc_carry: assert property (take && op_in == ret_rot_pkg::OP_RRC |=>
    flags_out[0] == $past(file_data_in[0]))
    else $error("right carry wrong");
  chk_rot_dest: assert property (take && rot |=> file_we_out == $past(dest_in))
    else $error("rotate destination wrong");
  chk_access_bank: assert property (take && rot && !access_in |=>
    file_bank_out == ret_rot_pkg::ACCESS_BANK)
    else $error("access bank not used");
endmodule
`default_nettype wire

// ==== tb/return_and_rotate_exec_tb.sv ====
// Self-checking bench for the return and rotate slice.
// Drives every port at the falling edge of a 25 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`define CK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t: %h %h", $time, a, e); end end
module return_and_rotate_exec_tb;
  logic clk_in, rst_in, op_valid_in, shadow_sel_in, dest_in, access_in, high_priority_in;
  logic latch_we_in, global_int_enable_high_out, peripheral_int_enable_low_out;
  logic stack_pop_out, pc_load_out, file_we_out, busy_out, master_clear_out;
  logic [7:0] literal_in, file_data_in, working_shadow_in, latch_upper_in, latch_high_in;
  logic [7:0] working_out, pc_latch_upper_out, pc_latch_high_out, file_wdata_out;
  logic [20:0] stack_top_in, pc_value_out;
  logic [4:0] flags_shadow_in, flags_out;
  logic [3:0] bank_select_shadow_in, bank_select_reg_out, file_bank_out;
  ret_rot_pkg::op_t op_in;
  int n_mismatch = 0;
  int checks = 0;
  return_and_rotate_exec i_return_and_rotate_exec (.clk_in, .rst_in, .op_valid_in, .op_in,
    .shadow_sel_in, .dest_in, .access_in, .literal_in, .high_priority_in, .file_data_in,
    .stack_top_in, .working_shadow_in, .flags_shadow_in, .bank_select_shadow_in,
    .latch_we_in, .latch_upper_in, .latch_high_in, .working_out, .flags_out,
    .bank_select_reg_out, .pc_latch_upper_out, .pc_latch_high_out,
    .global_int_enable_high_out, .peripheral_int_enable_low_out, .stack_pop_out,
    .pc_load_out, .pc_value_out, .file_we_out, .file_wdata_out, .file_bank_out, .busy_out,
    .master_clear_out);
  task automatic close_out;
    if (n_mismatch == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic go(input ret_rot_pkg::op_t o, input logic lw = 1'h0);
    @(negedge clk_in);
    op_in = o;
    op_valid_in = 1'h1;
    latch_we_in = lw;
    @(negedge clk_in);
    op_valid_in = 1'h0;
    latch_we_in = 1'h0;
  endtask
  task automatic rot(input ret_rot_pkg::op_t o, input logic d, a, input logic [7:0] f, r,
    input logic [4:0] fl, input logic [3:0] bk);
    {dest_in, access_in, file_data_in} = {d, a, f};
    go(o);
    `CK(d ? file_wdata_out : working_out, r)
    `CK({file_we_out, flags_out, file_bank_out}, {d, fl, bk})
  endtask
  initial
  begin
    clk_in = 1'h0;
    forever #20 clk_in = ~clk_in;
  end
  initial
  begin
    rst_in = 1'h1;
    op_in = ret_rot_pkg::OP_NONE;
    {op_valid_in, shadow_sel_in, dest_in, access_in, high_priority_in, latch_we_in} = '0;
    {literal_in, file_data_in, working_shadow_in, latch_upper_in, latch_high_in} = '0;
    {stack_top_in, flags_shadow_in, bank_select_shadow_in} = '0;
    repeat (4) @(negedge clk_in);
    rst_in = 1'h0;
    `CK(working_out, ret_rot_pkg::W_RESET)
    {latch_we_in, latch_upper_in, latch_high_in} = {1'h1, 16'h1234};
    @(negedge clk_in);
    latch_we_in = 1'h0;
    {working_shadow_in, flags_shadow_in, bank_select_shadow_in} = {8'h5A, 5'h04, 4'h3};
    {shadow_sel_in, high_priority_in, stack_top_in} = {2'h3, 21'h1ABCD};
    go(ret_rot_pkg::OP_RETFI);
    `CK({stack_pop_out, pc_load_out, busy_out, pc_value_out}, {3'h7, 21'h1ABCD})
    `CK({working_out, flags_out, bank_select_reg_out}, {8'h5A, 5'h04, 4'h3})
    `CK({global_int_enable_high_out, peripheral_int_enable_low_out}, 2'h2)
    {shadow_sel_in, working_shadow_in, stack_top_in} = {1'h0, 8'hA5, 21'h00222};
    {latch_upper_in, latch_high_in} = 16'hABCD;
    go(ret_rot_pkg::OP_RETSUB, 1'h1);
    `CK({pc_value_out, working_out, flags_out}, {21'h00222, 8'h5A, 5'h04})
    `CK({pc_latch_upper_out, pc_latch_high_out}, 16'h1234)
    {literal_in, stack_top_in} = {8'h77, 21'h00333};
    go(ret_rot_pkg::OP_RETLIT);
    `CK({pc_value_out, working_out, pc_latch_high_out}, {21'h00333, 16'h7734})
    high_priority_in = 1'h0;
    go(ret_rot_pkg::OP_RETFI);
    `CK({peripheral_int_enable_low_out, working_out}, {1'h1, 8'h77})
    // An op offered in the idle second cycle must be ignored
    literal_in = 8'h99;
    op_in = ret_rot_pkg::OP_RETLIT;
    op_valid_in = 1'h1;
    @(negedge clk_in);
    op_valid_in = 1'h0;
    `CK({stack_pop_out, pc_load_out, working_out}, {2'h0, 8'h77})
    rot(ret_rot_pkg::OP_RLC, 1'h0, 1'h1, 8'hE6, 8'hCC, 5'h11, 4'h3);
    rot(ret_rot_pkg::OP_RRC, 1'h1, 1'h0, 8'h01, 8'h80, 5'h11, 4'h0);
    rot(ret_rot_pkg::OP_RLNC, 1'h0, 1'h1, 8'h80, 8'h01, 5'h01, 4'h3);
    rot(ret_rot_pkg::OP_RLNC, 1'h1, 1'h1, 8'h00, 8'h00, 5'h05, 4'h3);
    go(ret_rot_pkg::OP_SWRESET);
    `CK({master_clear_out, working_out, flags_out, bank_select_reg_out}, 18'h20000)
    `CK({global_int_enable_high_out, pc_latch_upper_out}, 9'h000)
    close_out();
  end
endmodule
bind return_and_rotate_exec ret_rot_properties i_ret_rot_properties (.clk_in, .rst_in,
  .op_valid_in, .op_in, .dest_in, .access_in, .literal_in, .file_data_in, .stack_top_in,
  .working_out, .flags_out, .stack_pop_out, .pc_load_out, .pc_value_out, .file_we_out,
  .file_bank_out, .busy_out);
`default_nettype wire
